// ---- hw/hid_impedance_detect.sv ----
// Headphone impedance detect controller: registers, scheduling and sweep
`timescale 1ns/1ps
`default_nettype none

module hid_impedance_detect
  import hid_pkg::*;
#(
  parameter int unsigned SWEEP_CYCLES = SWEEP_BASE_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [31:0] busAddr,
  input  wire logic [31:0] busWdata,
  input  wire logic        busWrite,
  input  wire logic        busRead,
  output logic      [31:0] busRdata,
  input  wire logic        senseTrip,
  input  wire logic [14:0] levelCode,
  input  wire logic        micMeasReq,
  input  wire logic        micMeasBusy,
  output logic             hpdActive,
  output hid_route_s       route,
  output logic             sourceEnable,
  output logic      [9:0]  currentCode,
  output logic      [1:0]  spanSel,
  output logic             measComplete,
  output logic             measDonePulse
);

  // Synchronisers for the analog comparator and level code
  logic        tripMeta;
  logic        tripSync;
  logic [14:0] levelMeta;
  logic [14:0] levelSync;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tripMeta  <= 1'b0;
      tripSync  <= 1'b0;
      levelMeta <= LEVEL_CODE_RST;
      levelSync <= LEVEL_CODE_RST;
    end else begin
      tripMeta  <= senseTrip;
      tripSync  <= tripMeta;
      levelMeta <= levelCode;
      levelSync <= levelMeta;
    end
  end

  // Pin select decode into switch one-hots; reserved codes close nothing
  function automatic logic [5:0] decodePin(input logic [3:0] code);
    logic [5:0] hot;
    hot = '0;
    case (code)
      PIN_FIRST_MIC:   hot[SW_FIRST_MIC]   = 1'b1;
      PIN_SECOND_MIC:  hot[SW_SECOND_MIC]  = 1'b1;
      PIN_LEFT_PHONE:  hot[SW_LEFT_PHONE]  = 1'b1;
      PIN_RIGHT_PHONE: hot[SW_RIGHT_PHONE] = 1'b1;
      PIN_FIRST_JACK:  hot[SW_FIRST_JACK]  = 1'b1;
      PIN_SECOND_JACK: hot[SW_SECOND_JACK] = 1'b1;
      default:         hot = '0;
    endcase
    return hot;
  endfunction

  // Register state
  hid_pin_cfg_s   pinCfg;
  hid_pin_cfg_s   next_pinCfg;
  hid_sweep_cfg_s sweepCfg;
  hid_sweep_cfg_s next_sweepCfg;
  logic [31:0]    next_busRdata;
  logic           narrowAddr;
  logic           trigWrite;
  logic [15:0]    pinImage;
  logic [15:0]    rangeImage;
  logic [15:0]    statusImage;
  logic           phoneSense;
  logic [9:0]     rawCode;
  logic [14:0]    levelHeld;

  assign phoneSense = (pinCfg.senseSel == PIN_LEFT_PHONE) ||
                      (pinCfg.senseSel == PIN_RIGHT_PHONE);

  always_comb begin
    narrowAddr    = (busAddr < ADDR_WIDE_START);
    trigWrite     = busWrite && narrowAddr && (busAddr == REG_RANGE_SWEEP) &&
                    busWdata[TRIG_BIT];
    next_pinCfg   = pinCfg;
    next_sweepCfg = sweepCfg;
    if (busWrite && narrowAddr && (busAddr == REG_PIN_CONFIG)) begin
      next_pinCfg.ovdEna     = busWdata[OVD_BIT];
      next_pinCfg.chanSel    = busWdata[CHAN_LSB +: 3];
      next_pinCfg.currentSel = busWdata[CURR_LSB +: 4];
      next_pinCfg.senseSel   = busWdata[SENSE_LSB +: 4];
      next_pinCfg.returnSel  = busWdata[RET_LSB +: 3];
    end
    if (busWrite && narrowAddr && (busAddr == REG_RANGE_SWEEP)) begin
      next_sweepCfg.span     = busWdata[SPAN_LSB +: 2];
      next_sweepCfg.clkDiv   = busWdata[DIV_LSB +: 2];
      next_sweepCfg.stepSize = busWdata[STEP_LSB +: 2];
    end

    pinImage                   = '0;
    pinImage[OVD_BIT]          = pinCfg.ovdEna;
    pinImage[CHAN_LSB +: 3]    = pinCfg.chanSel;
    pinImage[CURR_LSB +: 4]    = pinCfg.currentSel;
    pinImage[SENSE_LSB +: 4]   = pinCfg.senseSel;
    pinImage[RET_LSB +: 3]     = pinCfg.returnSel;
    rangeImage                 = '0;
    rangeImage[SPAN_LSB +: 2]  = sweepCfg.span;
    rangeImage[DIV_LSB +: 2]   = sweepCfg.clkDiv;
    rangeImage[STEP_LSB +: 2]  = sweepCfg.stepSize;
    rangeImage[TRIG_BIT]       = 1'b0;
    statusImage                = '0;
    statusImage[DONE_BIT]      = measComplete;
    statusImage[LEVEL_LSB +: 15] = levelHeld;

    // Registers below the wide boundary are 16 bits; upper half reads zero
    next_busRdata = '0;
    if (busRead && narrowAddr) begin
      case (busAddr)
        REG_PIN_CONFIG:  next_busRdata = {16'h0000, pinImage};
        REG_RANGE_SWEEP: next_busRdata = {16'h0000, rangeImage};
        REG_STATUS:      next_busRdata = {16'h0000, statusImage};
        REG_RAW_CODE:    next_busRdata = {22'h000000, rawCode};
        default:         next_busRdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pinCfg   <= hid_pin_cfg_s'({PIN_CONFIG_RST[OVD_BIT], PIN_CONFIG_RST[CHAN_LSB +: 3],
                                  PIN_CONFIG_RST[CURR_LSB +: 4],
                                  PIN_CONFIG_RST[SENSE_LSB +: 4],
                                  PIN_CONFIG_RST[RET_LSB +: 3]});
      sweepCfg <= hid_sweep_cfg_s'({RANGE_SWEEP_RST[SPAN_LSB +: 2],
                                    RANGE_SWEEP_RST[DIV_LSB +: 2],
                                    RANGE_SWEEP_RST[STEP_LSB +: 2]});
      busRdata <= '0;
    end else begin
      pinCfg   <= next_pinCfg;
      sweepCfg <= next_sweepCfg;
      busRdata <= next_busRdata;
    end
  end

  // Sweep pacing
  logic sweepTick;
  logic pacerRun;

  hid_sweep_pacer #(
    .BASE_CYCLES (SWEEP_CYCLES)
  ) u_pacer (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .run    (pacerRun),
    .clkDiv (sweepCfg.clkDiv),
    .tick   (sweepTick)
  );

  // Measurement sequencer
  hid_state_e state;
  hid_state_e next_state;
  logic [9:0] next_currentCode;
  logic [9:0] stepVal;
  logic [9:0] next_rawCode;
  logic [14:0] next_levelHeld;
  logic       next_measComplete;
  logic       next_measDonePulse;
  logic       next_hpdActive;
  logic       next_sourceEnable;
  logic [1:0] next_spanSel;
  hid_route_s next_route;

  assign pacerRun = (state == ST_SWEEP);

  always_comb begin
    case (sweepCfg.stepSize)
      STEP_TWO:  stepVal = 10'd2;
      STEP_FOUR: stepVal = 10'd4;
      default:   stepVal = 10'd1;
    endcase

    next_state         = state;
    next_currentCode   = currentCode;
    next_rawCode       = rawCode;
    next_levelHeld     = levelHeld;
    next_measComplete  = measComplete;
    next_measDonePulse = 1'b0;

    case (state)
      ST_IDLE: begin
        if (trigWrite) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Mic detect has priority when both want the shared measurement path
        if (!micMeasBusy && !micMeasReq) begin
          next_state       = ST_SWEEP;
          next_currentCode = '0;
        end
      end
      ST_SWEEP: begin
        if (sweepTick) begin
          if (tripSync) begin
            next_state = ST_DONE;
          end else if (currentCode > (RAW_MAX - stepVal)) begin
            next_currentCode = RAW_MAX;
            next_state       = ST_DONE;
          end else begin
            next_currentCode = currentCode + stepVal;
          end
        end
      end
      ST_DONE: begin
        next_rawCode       = phoneSense ? currentCode : RAW_CODE_RST;
        next_levelHeld     = levelSync;
        next_measDonePulse = 1'b1;
        next_state         = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    // A trigger clears the flag; finishing sets it, and the set wins
    if (trigWrite && (state == ST_IDLE)) begin
      next_measComplete = 1'b0;
    end
    if (state == ST_DONE) begin
      next_measComplete = 1'b1;
    end

    next_hpdActive    = (next_state == ST_SWEEP);
    next_sourceEnable = (next_state == ST_SWEEP);
    next_spanSel      = phoneSense ? sweepCfg.span : SPAN_NONE;
    next_route        = '0;
    if (next_state == ST_SWEEP) begin
      next_route.sense    = decodePin(pinCfg.senseSel);
      next_route.current  = decodePin(pinCfg.currentSel);
      next_route.ret[0]   = (pinCfg.returnSel == RET_FIRST_FB);
      next_route.ret[1]   = (pinCfg.returnSel == RET_SECOND_FB);
      next_route.ovdLeft  = pinCfg.ovdEna && (pinCfg.chanSel == CHAN_LEFT);
      next_route.ovdRight = pinCfg.ovdEna && (pinCfg.chanSel == CHAN_RIGHT);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state         <= ST_IDLE;
      currentCode   <= RAW_CODE_RST;
      rawCode       <= RAW_CODE_RST;
      levelHeld     <= LEVEL_CODE_RST;
      measComplete  <= 1'b0;
      measDonePulse <= 1'b0;
      hpdActive     <= 1'b0;
      sourceEnable  <= 1'b0;
      spanSel       <= SPAN_NONE;
      route         <= '0;
    end else begin
      state         <= next_state;
      currentCode   <= next_currentCode;
      rawCode       <= next_rawCode;
      levelHeld     <= next_levelHeld;
      measComplete  <= next_measComplete;
      measDonePulse <= next_measDonePulse;
      hpdActive     <= next_hpdActive;
      sourceEnable  <= next_sourceEnable;
      spanSel       <= next_spanSel;
      route         <= next_route;
    end
  end

endmodule // hid_impedance_detect
`default_nettype wire

// ---- hw/hid_pkg.sv ----
// Package for the headphone impedance detect controller: map, fields, types
package hid_pkg;

  // Clock and sweep pacing
  localparam int unsigned MCLK_HZ           = 20_000_000;
  localparam int unsigned SWEEP_BASE_HZ     = 32_000;
  localparam int unsigned SWEEP_BASE_CYCLES = MCLK_HZ / SWEEP_BASE_HZ;

  // Register indices (bus address equals the register index)
  localparam logic [31:0] ADDR_WIDE_START   = 32'h0000_3000;
  localparam logic [31:0] REG_PIN_CONFIG    = 32'h0000_0299;
  localparam logic [31:0] REG_RANGE_SWEEP   = 32'h0000_029b;
  localparam logic [31:0] REG_STATUS        = 32'h0000_029c;
  localparam logic [31:0] REG_RAW_CODE      = 32'h0000_029d;

  // Field positions, pin configuration register
  localparam int RET_LSB    = 0;
  localparam int SENSE_LSB  = 4;
  localparam int CURR_LSB   = 8;
  localparam int CHAN_LSB   = 12;
  localparam int OVD_BIT    = 15;
  // Field positions, range and sweep register
  localparam int TRIG_BIT   = 0;
  localparam int STEP_LSB   = 1;
  localparam int DIV_LSB    = 3;
  localparam int SPAN_LSB   = 9;
  // Field positions, status register
  localparam int LEVEL_LSB  = 0;
  localparam int DONE_BIT   = 15;

  // Reset values
  localparam logic [15:0] PIN_CONFIG_RST  = 16'h0000;
  localparam logic [15:0] RANGE_SWEEP_RST = 16'h0000;
  localparam logic [9:0]  RAW_CODE_RST    = 10'h000;
  localparam logic [14:0] LEVEL_CODE_RST  = 15'h0000;

  // Pin encodings shared by sense and current select
  localparam logic [3:0] PIN_FIRST_MIC   = 4'h0;
  localparam logic [3:0] PIN_SECOND_MIC  = 4'h1;
  localparam logic [3:0] PIN_LEFT_PHONE  = 4'h4;
  localparam logic [3:0] PIN_RIGHT_PHONE = 4'h5;
  localparam logic [3:0] PIN_FIRST_JACK  = 4'h6;
  localparam logic [3:0] PIN_SECOND_JACK = 4'h7;
  localparam logic [2:0] RET_FIRST_FB    = 3'h0;
  localparam logic [2:0] RET_SECOND_FB   = 3'h1;
  localparam logic [2:0] CHAN_LEFT       = 3'h0;
  localparam logic [2:0] CHAN_RIGHT      = 3'h1;

  // One-hot switch positions
  localparam int SW_FIRST_MIC   = 0;
  localparam int SW_SECOND_MIC  = 1;
  localparam int SW_LEFT_PHONE  = 2;
  localparam int SW_RIGHT_PHONE = 3;
  localparam int SW_FIRST_JACK  = 4;
  localparam int SW_SECOND_JACK = 5;

  // Sweep step codes and current code limit
  localparam logic [1:0] STEP_ONE  = 2'h0;
  localparam logic [1:0] STEP_TWO  = 2'h1;
  localparam logic [1:0] STEP_FOUR = 2'h2;
  localparam logic [1:0] SPAN_NONE = 2'h0;
  localparam logic [9:0] RAW_MAX   = 10'h3ff;

  typedef struct packed {
    logic       ovdEna;
    logic [2:0] chanSel;
    logic [3:0] currentSel;
    logic [3:0] senseSel;
    logic [2:0] returnSel;
  } hid_pin_cfg_s;

  typedef struct packed {
    logic [1:0] span;
    logic [1:0] clkDiv;
    logic [1:0] stepSize;
  } hid_sweep_cfg_s;

  typedef struct packed {
    logic [5:0] sense;
    logic [5:0] current;
    logic [1:0] ret;
    logic       ovdLeft;
    logic       ovdRight;
  } hid_route_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_SWEEP = 2'b11,
    ST_DONE  = 2'b10
  } hid_state_e;

endpackage

// ---- hw/hid_sweep_pacer.sv ----
// Sweep pacer: one-cycle tick at the selected current source step rate
`timescale 1ns/1ps
`default_nettype none
module hid_sweep_pacer
  import hid_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = SWEEP_BASE_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       run,
  input  wire logic [1:0] clkDiv,
  output logic            tick
);

  localparam int CW = $clog2(BASE_CYCLES * 8 + 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [CW-1:0] limit;
  logic          next_tick;

  // Divider code 00..11 gives the base rate divided by 1, 2, 4, 8
  always_comb begin
    limit     = CW'((BASE_CYCLES << clkDiv) - 1);
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (!run) begin
      next_cnt = '0;
    end else if (cnt >= limit) begin
      next_cnt  = '0;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + CW'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule // hid_sweep_pacer
`default_nettype wire

// ---- verification/hid_impedance_detect_chk.sv ----
// Port checker for the impedance detect controller
`timescale 1ns/1ps
`default_nettype none
module hid_impedance_detect_chk
  import hid_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic [31:0] busAddr,
  input wire logic [31:0] busWdata,
  input wire logic        busWrite,
  input wire logic        busRead,
  input wire logic [31:0] busRdata,
  input wire logic        micMeasReq,
  input wire logic        micMeasBusy,
  input wire logic        hpdActive,
  input wire hid_route_s  route,
  input wire logic        sourceEnable,
  input wire logic [9:0]  currentCode,
  input wire logic [1:0]  spanSel,
  input wire logic        measComplete,
  input wire logic        measDonePulse
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire logic trigWr = busWrite && busAddr == REG_RANGE_SWEEP && busWdata[TRIG_BIT];
  // Sweep end: flag and one-cycle event next cycle, event gone after
  sequence seqFinish;
    ##1 (measDonePulse && measComplete) ##1 !measDonePulse;
  endsequence
  AST_FINISH: assert property ($fell(hpdActive) |-> seqFinish)
    else $error("completion did not follow sweep end");
  AST_HOLD: assert property (measComplete && !trigWr |=> measComplete)
    else $error("complete flag dropped without trigger");
  AST_CLEAR: assert property (trigWr && measComplete |=> !measComplete)
    else $error("trigger did not clear complete flag");
  AST_PULSE: assert property (measDonePulse |-> !$past(measComplete))
    else $error("done event without new completion");
  AST_SRC: assert property (sourceEnable == hpdActive)
    else $error("source enable differs from active");
  AST_IDLE: assert property (!hpdActive |-> route == '0)
    else $error("route closed outside sweep");
  AST_SCHED: assert property ($rose(hpdActive) |-> !$past(micMeasReq) && !$past(micMeasBusy))
    else $error("sweep started over mic measurement");
  AST_START: assert property ($rose(hpdActive) |-> currentCode == 10'h0)
    else $error("sweep did not start at zero");
  AST_STEP: assert property (hpdActive && $past(hpdActive) && currentCode != $past(currentCode)
    |-> (currentCode - $past(currentCode)) inside {10'h1, 10'h2, 10'h4} || currentCode == 10'h3ff)
    else $error("illegal sweep step");
  AST_SPAN: assert property (hpdActive && !(route.sense[SW_LEFT_PHONE] || route.sense[SW_RIGHT_PHONE])
    |-> spanSel == 2'h0)
    else $error("span applied off phone pin");
  AST_RDATA: assert property (!$past(busRead) |-> busRdata == 32'h0)
    else $error("read data outside read cycle");
endmodule // hid_impedance_detect_chk

bind hid_impedance_detect hid_impedance_detect_chk i_chk (
  .mclk(mclk), .rst_b(rst_b), .busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite),
  .busRead(busRead), .busRdata(busRdata), .micMeasReq(micMeasReq), .micMeasBusy(micMeasBusy),
  .hpdActive(hpdActive), .route(route), .sourceEnable(sourceEnable), .currentCode(currentCode),
  .spanSel(spanSel), .measComplete(measComplete), .measDonePulse(measDonePulse));
`default_nettype wire

// ---- verification/hid_analog_model.sv ----
// Analog front end model: load comparator and level code
`timescale 1ns/1ps
`default_nettype none
module hid_analog_model
  import hid_pkg::*;
#(
  parameter logic [14:0] LEVEL = 15'h1234
) (
  input  wire logic        sourceEnable,
  input  wire logic [9:0]  currentCode,
  input  wire logic [10:0] tripAt,
  output logic             senseTrip,
  output logic      [14:0] levelCode
);
  // Load trips once the forced current reaches its code; quiet with source off
  // Load sees only the forced current: output driver held off, shared bias left floating
  assign senseTrip = sourceEnable && ({1'b0, currentCode} >= tripAt);
  assign levelCode = LEVEL;
endmodule // hid_analog_model
`default_nettype wire

// ---- verification/hid_impedance_detect_test.sv ----
// Self-checking bench for the impedance detect controller
`timescale 1ns/1ps
`default_nettype none
module hid_impedance_detect_test
  import hid_pkg::*;
;
  localparam int unsigned SWC = 4;
  localparam logic [14:0] LVL = 15'h2a5c;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [31:0] busAddr = 32'h0;
  logic [31:0] busWdata = 32'h0;
  logic        busWrite = 1'b0;
  logic        busRead = 1'b0;
  logic [31:0] busRdata;
  logic        senseTrip;
  logic [14:0] levelCode;
  logic        micMeasReq = 1'b0;
  logic        micMeasBusy = 1'b0;
  logic        hpdActive;
  logic        sourceEnable;
  logic        measComplete;
  logic        measDonePulse;
  hid_route_s  route;
  logic [9:0]  currentCode;
  logic [1:0]  spanSel;
  logic [10:0] tripAt = 11'h0;
  int          n_fail = 0;
  int          checks_done = 0;

  always #25 mclk = ~mclk;

  hid_impedance_detect #(.SWEEP_CYCLES(SWC)) i_hid_impedance_detect (
    .mclk(mclk), .rst_b(rst_b), .busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite),
    .busRead(busRead), .busRdata(busRdata), .senseTrip(senseTrip), .levelCode(levelCode),
    .micMeasReq(micMeasReq), .micMeasBusy(micMeasBusy), .hpdActive(hpdActive), .route(route),
    .sourceEnable(sourceEnable), .currentCode(currentCode), .spanSel(spanSel),
    .measComplete(measComplete), .measDonePulse(measDonePulse));

  hid_analog_model #(.LEVEL(LVL)) i_hid_analog_model (
    .sourceEnable(sourceEnable), .currentCode(currentCode), .tripAt(tripAt),
    .senseTrip(senseTrip), .levelCode(levelCode));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    busWrite <= 1'b1;
    busAddr <= a;
    busWdata <= d;
    @(posedge mclk);
    busWrite <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge mclk);
    busRead <= 1'b1;
    busAddr <= a;
    @(posedge mclk);
    busRead <= 1'b0;
    #1;
    chk(busRdata, exp);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic logic [5:0] onehot(input logic [3:0] p);
    case (p)
      PIN_FIRST_MIC:   onehot = 6'h01;
      PIN_SECOND_MIC:  onehot = 6'h02;
      PIN_LEFT_PHONE:  onehot = 6'h04;
      PIN_RIGHT_PHONE: onehot = 6'h08;
      PIN_FIRST_JACK:  onehot = 6'h10;
      PIN_SECOND_JACK: onehot = 6'h20;
      default:         onehot = 6'h00;
    endcase
  endfunction

  task automatic t_regs;
    rd(REG_PIN_CONFIG, 32'h0);
    rd(REG_STATUS, 32'h0);
    rd(REG_RAW_CODE, 32'h0);
    wr(REG_PIN_CONFIG, 32'hffff_ffff);
    rd(REG_PIN_CONFIG, 32'h0000_fff7);
    wr(REG_RANGE_SWEEP, 32'hffff_fffe);
    rd(REG_RANGE_SWEEP, 32'h0000_061e);
    wr(REG_STATUS, 32'hffff_ffff);
    rd(REG_STATUS, 32'h0);
    wr(ADDR_WIDE_START, 32'hffff_ffff);
    rd(ADDR_WIDE_START, 32'h0);
    rd(32'h0000_029a, 32'h0);
    $display("test registers done");
  endtask

  task automatic t_meas(input logic [3:0] s, input logic [2:0] r, input logic o,
                        input logic [2:0] c, input logic [1:0] sp, input logic [1:0] dv,
                        input logic [1:0] st, input logic [10:0] tr);
    logic        ph;
    logic [9:0]  inc;
    logic [10:0] exp;
    int          n;
    int          p;
    ph = (s == PIN_LEFT_PHONE) || (s == PIN_RIGHT_PHONE);
    inc = (st == STEP_TWO) ? 10'd2 : (st == STEP_FOUR) ? 10'd4 : 10'd1;
    exp = ((tr + inc - 1) / inc) * inc;
    if (exp > 11'h3ff)
      exp = 11'h3ff;
    p = SWC << dv;
    tripAt <= tr;
    wr(REG_PIN_CONFIG, {16'h0, o, c, s, s, 1'b0, r});
    wr(REG_RANGE_SWEEP, {16'h0, 5'h0, sp, 4'h0, dv, st, 1'b1});
    @(posedge mclk);
    #1;
    chk(measComplete, 1'b0);
    for (int i = 0; i < 50 && hpdActive !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk(route, {onehot(s), onehot(s), r == 3'h0 ? 2'h1 : r == 3'h1 ? 2'h2 : 2'h0,
                o && c == 3'h0, o && c == 3'h1});
    chk(spanSel, ph ? sp : 2'h0);
    n = 0;
    while (measDonePulse !== 1'b1 && n < 9000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(measComplete, 1'b1);
    chk(n >= (exp / inc) * p && n <= (exp / inc + 2) * p + 6, 1'b1);
    rd(REG_STATUS, {16'h0, 1'b1, LVL});
    rd(REG_RAW_CODE, ph ? {22'h0, exp[9:0]} : 32'h0);
    rd(REG_RANGE_SWEEP, {16'h0, 5'h0, sp, 4'h0, dv, st, 1'b0});
    $display("test measure sense %h done", s);
  endtask

  task automatic t_span;
    logic [1:0] sp;
    sp = 2'h1;
    t_meas(PIN_LEFT_PHONE, RET_FIRST_FB, 1'b1, CHAN_LEFT, sp, 2'h0, STEP_FOUR, 11'd120);
    if (currentCode < 10'd169)
      sp = sp + 2'h1;
    t_meas(PIN_LEFT_PHONE, RET_FIRST_FB, 1'b1, CHAN_LEFT, sp, 2'h0, STEP_FOUR, 11'd500);
    chk(currentCode >= 10'd169 && currentCode <= 10'd1017, 1'b1);
    $display("test span stepping done");
  endtask

  task automatic t_sched;
    @(posedge mclk);
    micMeasBusy <= 1'b1;
    micMeasReq <= 1'b1;
    wr(REG_RANGE_SWEEP, 32'h0000_0001);
    repeat (8) begin
      @(posedge mclk);
      #1;
      chk(hpdActive, 1'b0);
    end
    @(posedge mclk);
    micMeasBusy <= 1'b0;
    micMeasReq <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk(hpdActive, 1'b1);
    for (int i = 0; i < 9000 && measDonePulse !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk(measComplete, 1'b1);
    $display("test scheduling done");
  endtask

  initial begin
    #(20000 * 50);
    n_fail++;
    end_sim;
  end

  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    t_regs;
    t_meas(PIN_LEFT_PHONE, RET_FIRST_FB, 1'b1, CHAN_LEFT, 2'h1, 2'h0, STEP_ONE, 11'd20);
    t_meas(PIN_RIGHT_PHONE, RET_SECOND_FB, 1'b1, CHAN_RIGHT, 2'h2, 2'h1, STEP_TWO, 11'd15);
    t_meas(PIN_FIRST_JACK, RET_FIRST_FB, 1'b0, CHAN_LEFT, 2'h3, 2'h0, STEP_FOUR, 11'd9);
    t_meas(PIN_SECOND_JACK, RET_SECOND_FB, 1'b0, CHAN_RIGHT, 2'h1, 2'h2, 2'h3, 11'd3);
    t_meas(PIN_FIRST_MIC, RET_FIRST_FB, 1'b0, CHAN_LEFT, 2'h2, 2'h3, STEP_ONE, 11'd2);
    t_meas(PIN_SECOND_MIC, RET_SECOND_FB, 1'b0, CHAN_LEFT, 2'h1, 2'h0, STEP_TWO, 11'd6);
    t_meas(4'h2, 3'h5, 1'b0, CHAN_LEFT, 2'h1, 2'h0, STEP_ONE, 11'd4);
    t_meas(PIN_LEFT_PHONE, RET_FIRST_FB, 1'b1, 3'h4, 2'h3, 2'h0, STEP_FOUR, 11'd1100);
    t_span;
    t_sched;
    end_sim;
  end
endmodule // hid_impedance_detect_test
`default_nettype wire
